// ==== sswd_cfg.svh ====
// constants of the supply supervisor and watchdog block
`ifndef SSWD_CFG_SVH
`define SSWD_CFG_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSWD_CLK_HZ 40000000
`define SSWD_CYC_PER_MS (`SSWD_CLK_HZ / 1000)
`define SSWD_HOLD_MS 200
`define SSWD_HOLD_CYC (`SSWD_HOLD_MS * `SSWD_CYC_PER_MS)
`define SSWD_WD_LONG_MS 1400
`define SSWD_WD_LONG_CYC (`SSWD_WD_LONG_MS * `SSWD_CYC_PER_MS)
`define SSWD_WD_MID_MS 600
`define SSWD_WD_MID_CYC (`SSWD_WD_MID_MS * `SSWD_CYC_PER_MS)
`define SSWD_WD_SHORT_MS 200
`define SSWD_WD_SHORT_CYC (`SSWD_WD_SHORT_MS * `SSWD_CYC_PER_MS)
`define SSWD_NV_MS 10
`define SSWD_NV_CYC (`SSWD_NV_MS * `SSWD_CYC_PER_MS)
`define SSWD_CNT_W 26
// ----------------------------------------------------------------
// control register
// ----------------------------------------------------------------
`define SSWD_REG_ADDR 16'hFFFF
`define SSWD_B_HWPE 7
`define SSWD_B_WDH 6
`define SSWD_B_WDL 5
`define SSWD_B_BG1 4
`define SSWD_B_BG0 3
`define SSWD_B_RWL 2
`define SSWD_B_WL 1
`define SSWD_B_BG2 0
`define SSWD_CMD_WL_CLR 8'h00
`define SSWD_CMD_WL_SET 8'h02
`define SSWD_CMD_BOTH_SET 8'h06
`define SSWD_WD_OFF 2'h3
`define SSWD_NV_WD_RST 2'h3
`define SSWD_NV_BP_RST 3'h0
`define SSWD_NV_HWPE_RST 1'h0
// ----------------------------------------------------------------
// guarded ranges
// ----------------------------------------------------------------
`define SSWD_GUARD_Q4 13'h1800
`define SSWD_GUARD_HALF 13'h1000
`define SSWD_GUARD_P1 13'h0040
`define SSWD_GUARD_P2 13'h0080
`define SSWD_GUARD_P4 13'h0100
`define SSWD_GUARD_P8 13'h0200
`endif

// ==== sswd_ctrl.sv ====
// supervisor: reset timing, watchdog, two-wire slave front end and control register
`timescale 1ns/1ps
`include "sswd_cfg.svh"
module sswd_ctrl #(
  parameter int unsigned HOLD_CYC = `SSWD_HOLD_CYC,
  parameter int unsigned WD_LONG_CYC = `SSWD_WD_LONG_CYC,
  parameter int unsigned WD_MID_CYC = `SSWD_WD_MID_CYC,
  parameter int unsigned WD_SHORT_CYC = `SSWD_WD_SHORT_CYC,
  parameter int unsigned NV_CYC = `SSWD_NV_CYC,
  // slave identifier nibble: value arbitrary
  parameter logic [3:0] DEV_ID = 4'h5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic factory_init_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic v2_fail_out,
  output logic v2_fail_oe,
  input wire logic supply_ok,
  input wire logic second_supply_sense,
  input wire logic wp_pin,
  input wire logic programming_voltage,
  input wire logic [1:0] dev_sel,
  input wire logic arr_busy,
  input wire logic [7:0] arr_rd_data,
  output logic [12:0] arr_addr,
  output logic [7:0] arr_wr_data,
  output logic arr_wr_stb,
  output logic vtrip_prog_stb
);
  import sswd_pkg::*;

  localparam sswd_cnt_t HOLD_C = sswd_cnt_t'(HOLD_CYC);

  sswd_main_t st;
  sswd_main_t next_st;
  sswd_link_t lk;
  sswd_link_t next_lk;

  logic scl_s;
  logic scl_q;
  logic sda_s;
  logic sda_q;
  logic bit_ev;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic wp_s;
  logic vp_s;
  logic vok_s;
  logic ack_ok;
  logic hw_prot;
  logic wd_on;
  logic wd_expired;
  logic busy_all;
  logic is_reg;
  logic nv_hw_protect_enable;
  logic [1:0] nv_wd;
  logic [2:0] nv_bp;
  logic nv_busy;
  logic [7:0] ctrl_byte;

  function automatic sswd_cnt_t wd_limit(input logic [1:0] per);
    sswd_cnt_t l;
    l = sswd_cnt_t'(WD_LONG_CYC);
    unique case (per)
      2'h0: l = sswd_cnt_t'(WD_LONG_CYC);
      2'h1: l = sswd_cnt_t'(WD_MID_CYC);
      2'h2: l = sswd_cnt_t'(WD_SHORT_CYC);
      2'h3: l = sswd_cnt_t'(WD_LONG_CYC);
    endcase
    return l;
  endfunction

  // ----------------------------------------------------------------
  // link domain: one toggle per scl rise, bit held until the next rise
  // ----------------------------------------------------------------
  always_comb begin
    next_lk.tog = ~lk.tog;
    next_lk.bitv = sda_in;
  end

  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      lk <= '{tog: 1'b0, bitv: 1'b0};
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile store
  // ----------------------------------------------------------------
  sswd_nv_store #(
    .NV_CYC(NV_CYC)
  ) u_nv (
    .clk(clk),
    .factory_init_n(factory_init_n),
    .commit_stb(st.commit_stb),
    .commit_data(st.wdata),
    .hw_protect_enable(nv_hw_protect_enable),
    .wd(nv_wd),
    .bp(nv_bp),
    .busy(nv_busy)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign scl_s = st.scl_sy[1];
  assign scl_q = st.scl_sy[2];
  assign sda_s = st.sda_sy[1];
  assign sda_q = st.sda_sy[2];
  assign bit_ev = st.tog_sy[1] ^ st.tog_sy[2];
  assign scl_fall = scl_q & ~scl_s;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
  assign wp_s = st.wp_sy[1];
  assign vp_s = st.vp_sy[1];
  assign vok_s = st.vok_sy[1];
  assign hw_prot = wp_s & nv_hw_protect_enable;
  assign wd_on = (nv_wd != `SSWD_WD_OFF);
  assign wd_expired = wd_on && (st.wd_cnt >= wd_limit(nv_wd));
  assign busy_all = nv_busy | arr_busy;
  assign is_reg = (st.addr == `SSWD_REG_ADDR);

  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[`SSWD_B_HWPE] = nv_hw_protect_enable;
    ctrl_byte[`SSWD_B_WDH] = nv_wd[1];
    ctrl_byte[`SSWD_B_WDL] = nv_wd[0];
    ctrl_byte[`SSWD_B_BG1] = nv_bp[1];
    ctrl_byte[`SSWD_B_BG0] = nv_bp[0];
    ctrl_byte[`SSWD_B_RWL] = st.reg_write_latch;
    ctrl_byte[`SSWD_B_WL] = st.write_latch;
    ctrl_byte[`SSWD_B_BG2] = nv_bp[2];
  end

  always_comb begin
    ack_ok = 1'b0;
    unique case (st.state)
      ST_DEV: ack_ok = (st.shreg[7:4] == DEV_ID) && (st.shreg[2:1] == st.dsel_sy[3:2]) && !busy_all;
      ST_AHI, ST_ALO: ack_ok = 1'b1;
      ST_WDAT: begin
        if (st.dseen) begin
          ack_ok = 1'b0;
        end else if (is_reg || (vp_s && st.shreg == 8'h00)) begin
          ack_ok = st.write_latch || (is_reg && st.shreg == `SSWD_CMD_WL_SET);
        end else begin
          ack_ok = st.write_latch && !sswd_guarded(nv_bp, st.addr[12:0]);
        end
      end
      default: ack_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.scl_sy = {st.scl_sy[1:0], scl};
    next_st.sda_sy = {st.sda_sy[1:0], sda_in};
    next_st.tog_sy = {st.tog_sy[1:0], lk.tog};
    next_st.wp_sy = {st.wp_sy[0], wp_pin};
    next_st.vp_sy = {st.vp_sy[0], programming_voltage};
    next_st.vok_sy = {st.vok_sy[0], supply_ok};
    next_st.v2_sy = {st.v2_sy[0], second_supply_sense};
    next_st.dsel_sy = {st.dsel_sy[1:0], dev_sel};
    next_st.v2_fail = ~st.v2_sy[1];
    next_st.arr_wr_stb = 1'b0;
    next_st.vtrip_stb = 1'b0;
    next_st.commit_stb = 1'b0;

    // a watchdog bite restarts the same hold as a supply dip
    if (!vok_s || wd_expired) begin
      next_st.hold_cnt = '0;
    end else if (st.hold_cnt != HOLD_C) begin
      next_st.hold_cnt = st.hold_cnt + 1'b1;
    end
    next_st.rst_drv = (next_st.hold_cnt != HOLD_C);

    if (start_c || st.rst_drv || !wd_on) begin
      next_st.wd_cnt = '0;
    end else begin
      next_st.wd_cnt = st.wd_cnt + 1'b1;
    end

    // a reset asserting in this cycle also cancels a stop's pending action
    if (st.rst_drv || next_st.rst_drv) begin
      next_st.state = ST_IDLE;
      next_st.sda_drv = 1'b0;
      next_st.pend = PD_NONE;
    end else if (start_c) begin
      next_st.state = ST_DEV;
      next_st.bitn = 4'h0;
      next_st.sda_drv = 1'b0;
      next_st.pend = PD_NONE;
    end else if (stop_c) begin
      next_st.state = ST_IDLE;
      next_st.sda_drv = 1'b0;
      next_st.pend = PD_NONE;
      unique case (st.pend)
        PD_REG: begin
          if (st.reg_write_latch) begin
            if (!st.wdata[`SSWD_B_RWL]) begin
              next_st.reg_write_latch = 1'b0;
              next_st.commit_stb = !hw_prot;
            end
          end else if (st.wdata == `SSWD_CMD_WL_SET) begin
            next_st.write_latch = 1'b1;
          end else if (st.wdata == `SSWD_CMD_BOTH_SET) begin
            next_st.write_latch = 1'b1;
            next_st.reg_write_latch = 1'b1;
          end else if (st.wdata == `SSWD_CMD_WL_CLR) begin
            next_st.write_latch = 1'b0;
          end
        end
        PD_ARR: next_st.arr_wr_stb = !sswd_guarded(nv_bp, st.addr[12:0]);
        PD_VTRIP: next_st.vtrip_stb = 1'b1;
        PD_NONE: next_st.pend = PD_NONE;
      endcase
    end else if (st.state != ST_IDLE) begin
      if (bit_ev) begin
        if (st.bitn < 4'h8) begin
          next_st.shreg = {st.shreg[6:0], lk.bitv};
          next_st.bitn = st.bitn + 4'h1;
        end else if (st.bitn == 4'h9) begin
          next_st.mack = lk.bitv;
          next_st.bitn = 4'hA;
        end
      end
      if (scl_fall) begin
        if (st.bitn == 4'h8) begin
          next_st.bitn = 4'h9;
          next_st.acked = ack_ok;
          next_st.sda_drv = (st.state == ST_RDAT) ? 1'b0 : ack_ok;
        end else if (st.bitn == 4'hA) begin
          next_st.bitn = 4'h0;
          next_st.sda_drv = 1'b0;
          unique case (st.state)
            ST_DEV: begin
              if (!st.acked) begin
                next_st.state = ST_IDLE;
              end else if (st.shreg[0]) begin
                next_st.state = ST_RDAT;
                next_st.rd_reg = is_reg;
                next_st.tx = is_reg ? ctrl_byte : arr_rd_data;
                next_st.sda_drv = is_reg ? ~ctrl_byte[7] : ~arr_rd_data[7];
              end else begin
                next_st.state = ST_AHI;
              end
            end
            ST_AHI: begin
              next_st.addr[15:8] = st.shreg;
              next_st.state = ST_ALO;
            end
            ST_ALO: begin
              next_st.addr[7:0] = st.shreg;
              next_st.state = ST_WDAT;
              next_st.dseen = 1'b0;
            end
            ST_WDAT: begin
              next_st.dseen = 1'b1;
              if (st.dseen) begin
                next_st.pend = PD_NONE;
              end else if (st.acked) begin
                next_st.wdata = st.shreg;
                if (is_reg) begin
                  next_st.pend = PD_REG;
                end else if (vp_s && st.shreg == 8'h00) begin
                  next_st.pend = PD_VTRIP;
                end else begin
                  next_st.pend = PD_ARR;
                end
              end else if (!is_reg && st.write_latch && sswd_guarded(nv_bp, st.addr[12:0])) begin
                // a guarded attempt also drops the register latch
                next_st.reg_write_latch = 1'b0;
              end
            end
            ST_RDAT: begin
              if (st.rd_reg || st.mack) begin
                next_st.state = ST_IDLE;
              end else begin
                next_st.addr = st.addr + 16'h0001;
                next_st.tx = arr_rd_data;
                next_st.sda_drv = ~arr_rd_data[7];
              end
            end
            default: next_st.state = ST_IDLE;
          endcase
        end else if (st.state == ST_RDAT && st.bitn != 4'h0 && st.bitn < 4'h8) begin
          next_st.tx = {st.tx[6:0], 1'b0};
          next_st.sda_drv = ~st.tx[6];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.rst_drv <= 1'b1;
      st.state <= ST_IDLE;
      st.pend <= PD_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = st.sda_drv;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = st.rst_drv;
  assign v2_fail_out = 1'b0;
  assign v2_fail_oe = st.v2_fail;
  assign arr_addr = st.addr[12:0];
  assign arr_wr_data = st.wdata;
  assign arr_wr_stb = st.arr_wr_stb;
  assign vtrip_prog_stb = st.vtrip_stb;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_low_supply_rst: assert property (!vok_s |=> rst_pin_oe)
    else $error("reset not asserted on low supply");
  chk_release_after_hold: assert property ($fell(rst_pin_oe) |-> vok_s && $past(vok_s, 2))
    else $error("reset released without good supply");
  chk_wdog_bite: assert property (wd_expired |=> rst_pin_oe)
    else $error("watchdog timeout did not assert reset");
  chk_wdog_restart: assert property (start_c && !st.rst_drv |=> st.wd_cnt == '0)
    else $error("start condition did not restart watchdog");
  chk_abort_on_rst: assert property ($rose(rst_pin_oe) |=> st.state == ST_IDLE && !sda_oe)
    else $error("transaction survived reset");
  chk_no_write_rst: assert property (rst_pin_oe |-> !arr_wr_stb && !vtrip_prog_stb && !st.commit_stb)
    else $error("write started during reset");
  chk_nv_runs_on: assert property (nv_busy && $rose(rst_pin_oe) |=> nv_busy)
    else $error("store cycle cut by reset");
  chk_unlatched_nack: assert property (st.state == ST_WDAT && st.bitn == 4'h8 && scl_fall && !st.write_latch
    && !st.rst_drv && !start_c && !stop_c && !(is_reg && st.shreg == `SSWD_CMD_WL_SET) |=> !sda_oe)
    else $error("data acknowledged with write latch clear");
  chk_second_byte_nack: assert property (st.state == ST_WDAT && st.dseen && st.bitn == 4'h8 && scl_fall
    |=> !sda_oe)
    else $error("second data byte acknowledged");
  chk_guard_nack: assert property (st.state == ST_WDAT && st.bitn == 4'h8 && scl_fall && !is_reg
    && !vp_s && sswd_guarded(nv_bp, st.addr[12:0]) |=> !sda_oe)
    else $error("guarded data byte acknowledged");
  chk_latch_only: assert property (stop_c && st.pend == PD_REG && !st.reg_write_latch && !st.rst_drv
    |=> !st.commit_stb ##1 !nv_busy)
    else $error("latch write started a store cycle");
  chk_rlatch_clear: assert property (st.commit_stb |-> !st.reg_write_latch)
    else $error("register latch kept after store");

  cov_start: cover property (start_c && !st.rst_drv);
  cov_reg_store: cover property (st.commit_stb);
  cov_arr_write: cover property (arr_wr_stb);
  cov_bite: cover property (wd_expired);
endmodule

// ==== sswd_ctrl_tb.sv ====
// self-checking bench of the supervisor with a bus master model
`timescale 1ns/1ps
module sswd_ctrl_tb;
  logic clk = 1'b0;
  logic arst_n, factory_init_n, supply_ok, second_supply_sense, wp_pin, programming_voltage;
  logic scl, sda, sda_out, sda_oe, rst_pin_out, rst_pin_oe, v2_fail_out, v2_fail_oe, arr_wr_stb, vtrip_prog_stb;
  logic [7:0] arr_rd_data, arr_wr_data;
  logic [1:0] dev_sel;
  logic arr_busy;
  logic [12:0] arr_addr;
  logic [7:0] exq[$];
  logic [23:0] stq[$];
  logic [31:0] seed = 32'd77602;
  int fail_count = 0;
  int cmp_count = 0;
  int n;
  logic [12:0] pin [8] = '{13'h1FFF, 13'h1800, 13'h1000, 13'h0800, 13'h003F, 13'h007F, 13'h00FF, 13'h01FF};
  logic [12:0] pout [8] = '{13'h0000, 13'h17FF, 13'h0FFF, 13'h1FFF, 13'h0040, 13'h0080, 13'h0100, 13'h0200};
  always #12.5 clk = ~clk;
  // shortened counts keep the run small
  sswd_ctrl #(.HOLD_CYC(50), .WD_SHORT_CYC(80), .NV_CYC(20)) u_sswd_ctrl (
    .clk(clk), .arst_n(arst_n), .factory_init_n(factory_init_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .v2_fail_out(v2_fail_out),
    .v2_fail_oe(v2_fail_oe), .supply_ok(supply_ok), .second_supply_sense(second_supply_sense), .wp_pin(wp_pin),
    .programming_voltage(programming_voltage), .dev_sel(dev_sel), .arr_busy(arr_busy), .arr_rd_data(arr_rd_data),
    .arr_addr(arr_addr), .arr_wr_data(arr_wr_data), .arr_wr_stb(arr_wr_stb), .vtrip_prog_stb(vtrip_prog_stb));
  sswd_master_model u_sswd_master_model (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tally(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_bus(input logic [7:0] g, input logic [7:0] e);
    tally({16'h0000, g}, {16'h0000, e});
  endtask
  task automatic cmp_pin(input logic [23:0] g, input logic [23:0] e);
    tally(g, e);
  endtask
  // an unexpected result finds an empty queue and a mismatching marker
  always @(u_sswd_master_model.got) begin
    cmp_bus(u_sswd_master_model.got_val, (exq.size() > 0) ? exq.pop_front() : 8'hEE);
  end
  // strobes are looked at mid-cycle, where they have settled
  always @(negedge clk) begin
    if (arr_wr_stb === 1'b1 || vtrip_prog_stb === 1'b1)
      cmp_pin({vtrip_prog_stb, arr_wr_stb, 1'b0, arr_addr, arr_wr_data}, (stq.size() > 0) ? stq.pop_front() : 24'hEEEEEE);
  end
  task automatic xw(input logic [7:0] d, input logic [7:0] e);
    exq.push_back(e);
    u_sswd_master_model.xb(d, 1'b0);
  endtask
  task automatic head(input logic [15:0] a);
    u_sswd_master_model.start();
    xw(8'h50, 8'h00);
    xw(a[15:8], 8'h00);
    xw(a[7:0], 8'h00);
  endtask
  task automatic wtx(input logic [15:0] a, input logic [7:0] d, input logic nak);
    head(a);
    xw(d, {7'h00, nak});
    u_sswd_master_model.stop();
  endtask
  task automatic rtx(input logic [15:0] a, input logic [7:0] e);
    head(a);
    u_sswd_master_model.start();
    xw(8'h51, 8'h00);
    exq.push_back(e);
    u_sswd_master_model.xb(8'hFF, 1'b1);
    u_sswd_master_model.stop();
  endtask
  task automatic slv(input logic [7:0] b, input logic nak);
    u_sswd_master_model.start();
    xw(b, {7'h00, nak});
    u_sswd_master_model.stop();
  endtask
  task automatic probe(input logic [12:0] a, input logic nak);
    logic [7:0] d;
    d = 8'(rnd());
    if (!nak) stq.push_back({3'b010, a, d});
    wtx({3'b000, a}, d, nak);
  endtask
  task automatic wt(input logic lv, input int mx);
    n = 0;
    while (rst_pin_oe !== lv) begin
      @(negedge clk);
      n++;
      if (n > mx) begin
        fail_count++;
        close_out();
      end
    end
  endtask
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    factory_init_n = 1'b0;
    supply_ok = 1'b1;
    second_supply_sense = 1'b1;
    wp_pin = 1'b0;
    programming_voltage = 1'b0;
    dev_sel = 2'h0;
    arr_busy = 1'b0;
    arr_rd_data = 8'h00;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    factory_init_n = 1'b1;
    arr_rd_data = 8'(rnd());
    wt(1'b0, 200);
    cmp_pin({23'h0, n >= 50 && n <= 60}, 24'h1);
    repeat (4) @(negedge clk);
    rtx(16'hFFFF, 8'h60);
    wtx(16'h0010, 8'hA5, 1'b1);
    wtx(16'hFFFF, 8'h02, 1'b0);
    rtx(16'hFFFF, 8'h62);
    head(16'hFFFF);
    xw(8'h06, 8'h00);
    xw(8'h06, 8'h01);
    u_sswd_master_model.stop();
    wp_pin = 1'b1;
    // every guard code, with the protect pin following the code's low bit while the enable bit is clear
    for (int c = 0; c < 8; c++) begin
      wtx(16'hFFFF, 8'h06, 1'b0);
      wtx(16'hFFFF, {3'b011, c[1:0], 2'b00, c[2]}, 1'b0);
      repeat (40) @(negedge clk);
      rtx(16'hFFFF, {3'b011, c[1:0], 2'b01, c[2]});
      wp_pin = c[0];
      probe(pin[c], c != 0);
      probe(pout[c], c == 3);
    end
    programming_voltage = 1'b1;
    stq.push_back(24'h800000);
    wtx(16'h0000, 8'h00, 1'b0);
    programming_voltage = 1'b0;
    second_supply_sense = 1'b0;
    repeat (5) @(negedge clk);
    cmp_pin({23'h0, v2_fail_oe}, 24'h1);
    second_supply_sense = 1'b1;
    supply_ok = 1'b0;
    wt(1'b1, 5);
    slv(8'h50, 1'b1);
    supply_ok = 1'b1;
    wt(1'b0, 80);
    cmp_pin({23'h0, n >= 50 && n <= 60}, 24'h1);
    // select straps and a busy array both refuse the slave byte
    dev_sel = 2'h2;
    slv(8'h50, 1'b1);
    slv(8'h54, 1'b0);
    dev_sel = 2'h0;
    arr_busy = 1'b1;
    slv(8'h50, 1'b1);
    arr_busy = 1'b0;
    // enable set with the pin low; with the pin high the next store is refused
    wp_pin = 1'b0;
    wtx(16'hFFFF, 8'h06, 1'b0);
    wtx(16'hFFFF, 8'hE0, 1'b0);
    repeat (40) @(negedge clk);
    wp_pin = 1'b1;
    wtx(16'hFFFF, 8'h06, 1'b0);
    wtx(16'hFFFF, 8'h40, 1'b0);
    repeat (40) @(negedge clk);
    rtx(16'hFFFF, 8'hE2);
    wp_pin = 1'b0;
    wtx(16'hFFFF, 8'h06, 1'b0);
    wtx(16'hFFFF, 8'h40, 1'b0);
    wt(1'b1, 1000);
    wt(1'b0, 80);
    cmp_pin({23'h0, n >= 50 && n <= 60}, 24'h1);
    cmp_pin({22'h0, exq.size() == 0, stq.size() == 0}, 24'h3);
    close_out();
  end
endmodule

// ==== sswd_master_model.sv ====
// two-wire bus master model that drives scl and sda of the supervisor
`timescale 1ns/1ps
module sswd_master_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic m_low;
  logic [7:0] got_val;
  event got;
  // open drain with pull-up: a released line reads high, never the last value
  assign sda = ~(m_low | sda_oe);
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end
  // scl stands high between frames; a phase is long enough for the slave's synchronisers
  task automatic ph();
    repeat (6) @(negedge clk);
  endtask
  task automatic start();
    m_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    m_low = 1'b1;
    ph();
    scl = 1'b0;
  endtask
  task automatic stop();
    m_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    m_low = 1'b0;
    ph();
  endtask
  // eight bits out or in, then a released ninth bit; data changes only while scl is low
  task automatic xb(input logic [7:0] d, input logic rd);
    logic [8:0] v;
    logic [8:0] d9;
    d9 = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      m_low = ~d9[i];
      ph();
      scl = 1'b1;
      ph();
      v[i] = sda;
      scl = 1'b0;
    end
    got_val = rd ? v[8:1] : {7'h00, v[0]};
    -> got;
  endtask
endmodule

// ==== sswd_nv_store.sv ====
// nonvolatile copy of the watchdog period, guard and protect-enable bits
`timescale 1ns/1ps
`include "sswd_cfg.svh"
module sswd_nv_store #(
  parameter int unsigned NV_CYC = `SSWD_NV_CYC
) (
  input wire logic clk,
  input wire logic factory_init_n,
  input wire logic commit_stb,
  input wire logic [7:0] commit_data,
  output logic hw_protect_enable,
  output logic [1:0] wd,
  output logic [2:0] bp,
  output logic busy
);
  import sswd_pkg::*;

  localparam sswd_cnt_t NV_C = sswd_cnt_t'(NV_CYC);

  sswd_nv_t st;
  sswd_nv_t next_st;

  // ----------------------------------------------------------------
  // store cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (st.busy) begin
      next_st.cnt = st.cnt + 1'b1;
      if (st.cnt >= NV_C - 1'b1) begin
        // new values appear only once the cycle has ended
        next_st.busy = 1'b0;
        next_st.hw_protect_enable = st.pend[`SSWD_B_HWPE];
        next_st.wd = {st.pend[`SSWD_B_WDH], st.pend[`SSWD_B_WDL]};
        next_st.bp = {st.pend[`SSWD_B_BG2], st.pend[`SSWD_B_BG1], st.pend[`SSWD_B_BG0]};
      end
    end else if (commit_stb) begin
      next_st.busy = 1'b1;
      next_st.cnt = '0;
      next_st.pend = commit_data;
    end
  end

  // power-up reset does not reach here: these bits survive power loss
  always_ff @(posedge clk or negedge factory_init_n) begin
    if (!factory_init_n) begin
      st <= '{cnt: '0, busy: 1'b0, pend: 8'h00, hw_protect_enable: `SSWD_NV_HWPE_RST,
              wd: `SSWD_NV_WD_RST, bp: `SSWD_NV_BP_RST};
    end else begin
      st <= next_st;
    end
  end

  assign hw_protect_enable = st.hw_protect_enable;
  assign wd = st.wd;
  assign bp = st.bp;
  assign busy = st.busy;

  chk_nv_bits_stable: assert property (@(posedge clk) disable iff (!factory_init_n)
    !$past(st.busy) |-> $stable(st.wd) && $stable(st.bp) && $stable(st.hw_protect_enable))
    else $error("nonvolatile bits changed outside a store cycle");
endmodule

// ==== sswd_pkg.sv ====
// types and shared decoding of the supply supervisor and watchdog block
package sswd_pkg;
  `include "sswd_cfg.svh"

  typedef logic [`SSWD_CNT_W-1:0] sswd_cnt_t;

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDAT, ST_RDAT} sswd_state_t;

  typedef enum logic [1:0] {PD_NONE, PD_REG, PD_ARR, PD_VTRIP} sswd_pend_t;

  typedef struct packed {
    logic tog;
    logic bitv;
  } sswd_link_t;

  typedef struct packed {
    sswd_cnt_t cnt;
    logic busy;
    logic [7:0] pend;
    logic hw_protect_enable;
    logic [1:0] wd;
    logic [2:0] bp;
  } sswd_nv_t;

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic [2:0] tog_sy;
    logic [1:0] wp_sy;
    logic [1:0] vp_sy;
    logic [1:0] vok_sy;
    logic [1:0] v2_sy;
    logic [3:0] dsel_sy;
    sswd_cnt_t hold_cnt;
    logic rst_drv;
    sswd_cnt_t wd_cnt;
    sswd_state_t state;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic mack;
    logic acked;
    logic sda_drv;
    logic rd_reg;
    logic dseen;
    logic [15:0] addr;
    sswd_pend_t pend;
    logic [7:0] wdata;
    logic write_latch;
    logic reg_write_latch;
    logic arr_wr_stb;
    logic vtrip_stb;
    logic commit_stb;
    logic v2_fail;
  } sswd_main_t;

  // guarded range decode on the thirteen-bit array address
  function automatic logic sswd_guarded(input logic [2:0] bp, input logic [12:0] a);
    logic g;
    g = 1'b0;
    unique case (bp)
      3'h0: g = 1'b0;
      3'h1: g = (a >= `SSWD_GUARD_Q4);
      3'h2: g = (a >= `SSWD_GUARD_HALF);
      3'h3: g = 1'b1;
      3'h4: g = (a < `SSWD_GUARD_P1);
      3'h5: g = (a < `SSWD_GUARD_P2);
      3'h6: g = (a < `SSWD_GUARD_P4);
      3'h7: g = (a < `SSWD_GUARD_P8);
    endcase
    return g;
  endfunction
endpackage
